// file: rtl/vipp_pkg.sv
// package: register map, field layout and pixel carrier of the video input path
package vipp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEG_H = 8'h04;
  localparam logic [7:0] ADDR_DEG_V = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_COEF = 8'h10;
  localparam logic [7:0] ADDR_COEF_LAST = 8'h3C;
  localparam int COEF_NUM = 12;
  localparam int COEF_FRAC = 12;
  localparam logic [15:0] COEF_UNITY = 16'h1000;
  localparam logic [15:0] COEF_ZERO = 16'h0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam logic [31:0] DEG_RESET = 32'h0000_0000;
  // ctrl, deg and status field positions
  localparam int CTRL_FMT = 0;
  localparam int CTRL_SCALE = 2;
  localparam int CTRL_DDR = 4;
  localparam int CTRL_EMB = 5;
  localparam int CTRL_DEGEN = 6;
  localparam int CTRL_DEONLY = 7;
  localparam int CTRL_RBX = 8;
  localparam int CTRL_YCX = 9;
  localparam int CTRL_UP = 10;
  localparam int CTRL_CSC = 11;
  localparam int CTRL_DOWN = 12;
  localparam int DEG_ACT = 16;
  localparam int STAT_LINE = 16;
  // input formats
  localparam logic [1:0] FMT_RGB444 = 2'h0;
  localparam logic [1:0] FMT_YCC444 = 2'h1;
  localparam logic [1:0] FMT_YCC422 = 2'h2;
  localparam logic [1:0] FMT_SERIAL = 2'h3;
  // clock scale codes and the extra repeats they imply
  localparam logic [1:0] SCALE_HALF = 2'h0;
  localparam logic [1:0] SCALE_ONE = 2'h1;
  localparam logic [1:0] SCALE_TWO = 2'h2;
  localparam logic [1:0] SCALE_FOUR = 2'h3;
  localparam logic [1:0] REP_TWO = 2'h1;
  localparam logic [1:0] REP_FOUR = 2'h3;
  // embedded sync words, bits of the status word, bus responses and pin reset value
  localparam logic [7:0] SYNC_FF = 8'hFF;
  localparam logic [7:0] SYNC_00 = 8'h00;
  localparam int XY_F = 6;
  localparam int XY_V = 5;
  localparam int XY_H = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NPIN = 29;
  localparam logic [NPIN-1:0] PIN_RESET = 29'h1000_0000;
  typedef struct packed {
    logic [23:0] data;
    logic de;
    logic hs;
    logic vs;
    logic fld;
  } vipp_pix_type;
endpackage

// file: rtl/vipp_top.sv
// video input path: pin capture, sync recovery, chroma resampling, colour matrix
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Contract
// - input bus 8 to 24 bits wide, width and format chosen by ctrl
// - pixel rate scaled by 0.5, 1, 2 or 4 under register control
// - embedded-sync formats recover hsync, vsync and de from sync codes
// - sync code is FF, 00, 00 then XY carrying field, blanking bits
// - without source de, generate de from hsync, vsync and pixel clock
// - 4:2:2 input to 4:4:4 output enables chroma upsampling
// - 4:4:4 input to 4:2:2 output enables chroma downsampling
// - colour matrix between RGB and YCbCr, all coefficients programmable
// - every stage enabled or bypassed by register; host keeps choices consistent
// - 24-bit 4:4:4 input may exchange red and blue lanes
// - 4:2:2 parallel input may exchange luma and chroma lanes
// - byte-serial 4:2:2 with embedded sync, chroma and luma interleaved
// - path serves its whole range of output pixel rates
// - 13.5 MHz interlaced sources use pixel repetition to reach 27 MHz
// - low hw_reset_n returns all stages and settings to defaults
module vipp_top #(
  parameter int LINE_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [vipp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [vipp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hw_reset_n,
  input wire logic pix_clk,
  input wire logic pix_de,
  input wire logic pix_hsync,
  input wire logic pix_vsync,
  input wire logic [23:0] pix_d,
  output vipp_pkg::vipp_pix_type out_pix,
  output logic out_valid
);
  import vipp_pkg::*;

  if (LINE_W < 8 || LINE_W > 16) begin : g_bad_width
    $error("LINE_W must lie between 8 and 16");
  end

  // ==========================================================
  // pin capture
  logic [NPIN-1:0] pin_s1, pin_s2, pin_s3, pin_f;
  logic rst, pclk_q, hs_q, vs_q;
  logic pclk_f, de_f, hs_f, vs_f;
  logic [23:0] d_f;

  // sampled pins: a change counts once two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= PIN_RESET;
      pin_s2 <= PIN_RESET;
      pin_s3 <= PIN_RESET;
      pin_f <= PIN_RESET;
    end else begin
      pin_s1 <= {hw_reset_n, pix_clk, pix_de, pix_hsync, pix_vsync, pix_d};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
    end
  end

  assign {pclk_f, de_f, hs_f, vs_f, d_f} = pin_f[NPIN-2:0];
  // pin reset clears settings and pipeline; bus state keeps aresetn only
  assign rst = !aresetn || !pin_f[NPIN-1];

  // ==========================================================
  // registers
  logic [31:0] ctrl, deg_h, deg_v;
  logic [15:0] coef [COEF_NUM];
  logic [1:0] fmt, scale;
  logic ddr, emb, degen, deonly;
  logic aw_ok, w_ok, do_wr;
  logic [ADDR_W-1:0] aw_q;
  logic [31:0] w_q, rd_val;
  logic [3:0] ws_q;
  logic [3:0] wr_idx, rd_idx;
  logic [LINE_W-1:0] hcnt, vcnt;
  logic emb_f, emb_v, emb_h;

  assign fmt = ctrl[CTRL_FMT +: 2];
  assign scale = ctrl[CTRL_SCALE +: 2];
  assign ddr = ctrl[CTRL_DDR];
  assign emb = ctrl[CTRL_EMB];
  assign degen = ctrl[CTRL_DEGEN];
  assign deonly = ctrl[CTRL_DEONLY];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) old[8*b +: 8] = nw[8*b +: 8];
    end
    return old;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'h0 && a <= ADDR_COEF_LAST;
  endfunction

  assign s_axi_awready = !aw_ok;
  assign s_axi_wready = !w_ok;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_ok && w_ok && !s_axi_bvalid;
  assign wr_idx = 4'(aw_q[5:2] - 4'h4);
  assign rd_idx = 4'(s_axi_araddr[5:2] - 4'h4);

  // address and data may arrive in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      aw_q <= '0;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_ok) begin
        aw_ok <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_ok) begin
        w_ok <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // settings and matrix; identity matrix after reset
  always_ff @(posedge aclk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      deg_h <= DEG_RESET;
      deg_v <= DEG_RESET;
      for (int i = 0; i < COEF_NUM; i++) begin
        coef[i] <= (i < 9 && i % 4 == 0) ? COEF_UNITY : COEF_ZERO;
      end
    end else if (do_wr) begin
      if (aw_q == ADDR_CTRL) begin
        ctrl <= merge(ctrl, w_q, ws_q);
      end else if (aw_q == ADDR_DEG_H) begin
        deg_h <= merge(deg_h, w_q, ws_q);
      end else if (aw_q == ADDR_DEG_V) begin
        deg_v <= merge(deg_v, w_q, ws_q);
      end else if (aw_q >= ADDR_COEF && mapped(aw_q)) begin
        coef[wr_idx] <= 16'(merge({16'h0000, coef[wr_idx]}, w_q, ws_q));
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == ADDR_CTRL) begin
      rd_val = ctrl;
    end else if (s_axi_araddr == ADDR_DEG_H) begin
      rd_val = deg_h;
    end else if (s_axi_araddr == ADDR_DEG_V) begin
      rd_val = deg_v;
    end else if (s_axi_araddr == ADDR_STATUS) begin
      rd_val = (32'(vcnt) << STAT_LINE) | 32'({emb_f, emb_v, emb_h});
    end else if (mapped(s_axi_araddr)) begin
      rd_val = {16'h0000, coef[rd_idx]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // edge detection, lane exchange and word assembly
  logic rise, fall, strobe, phase, code_hit, pre;
  logic [23:0] d_sw, w_d;
  logic [11:0] first;
  logic [7:0] code_b, h0, h1, h2;
  logic word_v, de_sel, hs_sel, vs_sel, gen_de;

  assign rise = pclk_f && !pclk_q;
  assign fall = !pclk_f && pclk_q;
  // double-edge capture takes both clock edges
  assign strobe = rise || (ddr && fall);

  always_comb begin
    d_sw = d_f;
    if (ctrl[CTRL_RBX] && (fmt == FMT_RGB444 || fmt == FMT_YCC444)) begin
      d_sw = {d_f[7:0], d_f[15:8], d_f[23:16]};
    end else if (ctrl[CTRL_YCX] && fmt == FMT_YCC422) begin
      d_sw = {d_f[11:0], d_f[23:12]};
    end
  end

  // code word sits on the serial lane or the parallel luma lane
  assign code_b = (fmt == FMT_SERIAL) ? d_sw[11:4] : d_sw[23:16];
  assign code_hit = emb && strobe && h2 == SYNC_FF && h1 == SYNC_00 && h0 == SYNC_00;
  // code words themselves never count as active samples
  assign pre = code_b == SYNC_FF || h0 == SYNC_FF || h1 == SYNC_FF || h2 == SYNC_FF;

  // recover blanking flags from the status word of each code
  always_ff @(posedge aclk) begin
    if (rst) begin
      {h0, h1, h2} <= {SYNC_00, SYNC_00, SYNC_00};
      {emb_f, emb_v, emb_h} <= 3'h0;
      phase <= 1'b0;
      first <= 12'h000;
      pclk_q <= 1'b0;
    end else begin
      pclk_q <= pclk_f;
      if (strobe) begin
        {h0, h1, h2} <= {code_b, h0, h1};
        first <= d_sw[11:0];
        // next sample after a code is chroma
        phase <= code_hit ? 1'b0 : !phase;
      end
      if (code_hit) begin
        {emb_f, emb_v, emb_h} <= {code_b[XY_F], code_b[XY_V], code_b[XY_H]};
      end
    end
  end

  // active region counted from sync edges and pixel words
  always_ff @(posedge aclk) begin
    if (rst) begin
      {hs_q, vs_q} <= 2'h0;
      hcnt <= '0;
      vcnt <= '0;
    end else begin
      {hs_q, vs_q} <= {hs_f, vs_f};
      if (hs_f && !hs_q) begin
        hcnt <= '0;
      end else if (word_v) begin
        hcnt <= hcnt + 1'b1;
      end
      if (vs_f && !vs_q) begin
        vcnt <= '0;
      end else if (hs_f && !hs_q) begin
        vcnt <= vcnt + 1'b1;
      end
    end
  end

  assign gen_de = hcnt >= deg_h[0 +: LINE_W]
    && {1'b0, hcnt} < {1'b0, deg_h[0 +: LINE_W]} + {1'b0, deg_h[DEG_ACT +: LINE_W]}
    && vcnt >= deg_v[0 +: LINE_W]
    && {1'b0, vcnt} < {1'b0, deg_v[0 +: LINE_W]} + {1'b0, deg_v[DEG_ACT +: LINE_W]};

  always_comb begin
    if (deonly) begin
      {de_sel, hs_sel, vs_sel} = {de_f, 1'b0, 1'b0};
    end else if (emb) begin
      {de_sel, hs_sel, vs_sel} = {!emb_h && !emb_v && !pre, emb_h, emb_v};
    end else if (degen) begin
      {de_sel, hs_sel, vs_sel} = {gen_de, hs_f, vs_f};
    end else begin
      {de_sel, hs_sel, vs_sel} = {de_f, hs_f, vs_f};
    end
    // map each bus width onto the internal word
    w_d = (fmt == FMT_YCC422) ? {8'h00, d_sw[23:16], d_sw[11:4]} : d_sw;
    word_v = strobe;
    if (ddr && fmt != FMT_SERIAL) begin
      word_v = fall;
      w_d = {d_sw[11:0], first};
    // half rate makes one pixel per two samples; only serial input pairs both samples into it
    end else if (scale == SCALE_HALF) begin
      word_v = strobe && phase;
      if (fmt == FMT_SERIAL) begin
        w_d = {8'h00, d_sw[11:4], first[11:4]};
      end
    end
  end

  // ==========================================================
  // processing stages, one register each
  vipp_pix_type cap, up, color_matrix_converter, dn;
  logic cap_v, up_v, csc_v, dn_v, cph, dph;
  logic [7:0] cb, cr, cb_n, cr_n;
  logic [23:0] mat;
  logic [1:0] rep_left;

  function automatic logic [7:0] mac(input logic [15:0] c0, input logic [15:0] c1,
                                     input logic [15:0] c2, input logic [15:0] off,
                                     input logic [23:0] x);
    logic signed [27:0] a;
    a = 28'(signed'(c0)) * 28'(signed'({1'b0, x[7:0]}))
      + 28'(signed'(c1)) * 28'(signed'({1'b0, x[15:8]}))
      + 28'(signed'(c2)) * 28'(signed'({1'b0, x[23:16]}));
    a = (a >>> COEF_FRAC) + 28'(signed'(off));
    if (a < 0) return 8'h00;
    if (a > 28'sd255) return 8'hFF;
    return a[7:0];
  endfunction

  // one matrix row per output component, clamped to 8 bits
  for (genvar k = 0; k < 3; k++) begin : g_row
    assign mat[8*k +: 8] = mac(coef[3*k], coef[3*k+1], coef[3*k+2], coef[9+k], up.data);
  end

  // sample-and-hold chroma; cheaper than an interpolating filter
  assign cb_n = cph ? cb : cap.data[7:0];
  assign cr_n = cph ? cap.data[7:0] : cr;

  // capture, upsample, matrix, downsample, each carrying its sync
  always_ff @(posedge aclk) begin
    if (rst) begin
      {cap, up, color_matrix_converter, dn} <= '0;
      {cap_v, up_v, csc_v, dn_v} <= 4'h0;
      {cph, dph} <= 2'h0;
      {cb, cr} <= 16'h0000;
    end else begin
      {cap_v, up_v, csc_v, dn_v} <= {word_v, cap_v, up_v, csc_v};
      if (word_v) begin
        cap <= '{data: w_d, de: de_sel, hs: hs_sel, vs: vs_sel, fld: emb_f};
      end
      if (cap_v) begin
        up <= cap;
        if (ctrl[CTRL_UP]) begin
          up.data <= {cr_n, cap.data[15:8], cb_n};
        end
        cph <= cap.de && !cph;
        {cb, cr} <= {cb_n, cr_n};
      end
      if (up_v) begin
        color_matrix_converter <= up;
        if (ctrl[CTRL_CSC]) begin
          color_matrix_converter.data <= mat;
        end
      end
      if (csc_v) begin
        dn <= color_matrix_converter;
        // decimate chroma, alternating blue and red difference
        if (ctrl[CTRL_DOWN]) begin
          dn.data <= {8'h00, color_matrix_converter.data[15:8], dph ? color_matrix_converter.data[23:16] : color_matrix_converter.data[7:0]};
        end
        dph <= color_matrix_converter.de && !dph;
      end
    end
  end

  // doubling or quadrupling repeats each finished pixel
  // one pixel per strobe, or per two strobes at half rate or parallel double-edge capture; repeats must end before the next
  always_ff @(posedge aclk) begin
    if (rst) begin
      out_pix <= '0;
      out_valid <= 1'b0;
      rep_left <= 2'h0;
    end else if (dn_v) begin
      out_pix <= dn;
      out_valid <= 1'b1;
      rep_left <= (scale == SCALE_FOUR) ? REP_FOUR : (scale == SCALE_TWO) ? REP_TWO : 2'h0;
    end else if (rep_left != 2'h0) begin
      out_valid <= 1'b1;
      rep_left <= rep_left - 2'h1;
    end else begin
      out_valid <= 1'b0;
    end
  end

endmodule

// file: dv/vipp_src_model.sv
// pixel source model driving the parallel video pins
`timescale 1ns/100ps
module vipp_src_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [26:0] w,
  input wire logic [3:0] hp,
  output logic pix_clk,
  output logic pix_de,
  output logic pix_hsync,
  output logic pix_vsync,
  output logic [23:0] pix_d,
  output logic busy
);
  // ==========================================
  // one pixel clock period per request
  // the clock stands low between requests
  initial begin
    pix_clk = 1'h0;
    busy = 1'h0;
    {pix_de, pix_hsync, pix_vsync, pix_d} = 27'h0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'h1;
        {pix_de, pix_hsync, pix_vsync, pix_d} <= w;
        repeat (hp) @(posedge aclk);
        pix_clk <= 1'h1;
        repeat (hp) @(posedge aclk);
        pix_clk <= 1'h0;
        repeat (hp) @(posedge aclk);
        // released bus must not look like valid data
        pix_d <= ~pix_d;
        busy <= 1'h0;
      end
    end
  end
endmodule

// file: dv/vipp_chk_assertions.sv
// timing checker for the video input path ports
`timescale 1ns/100ps
module vipp_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [vipp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hw_reset_n,
  input wire logic out_valid
);
  import vipp_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // register bus
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
    else $error("read response dropped early");
  AST_AR_BLOCK: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  AST_RD_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // both items held one cycle, answer registered the cycle after
  AST_WR_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_W_BLOCK: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  AST_RD_UNMAPPED: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_COEF_LAST
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // ==========================================
  // pixel output
  AST_REPEAT_MAX: assert property (
    out_valid [*4] |=> !out_valid)
    else $error("pixel repeated more than four times");
  AST_HW_RESET: assert property (
    !hw_reset_n [*5] |=> !out_valid)
    else $error("output alive under pin reset");
  AST_RST_IDLE: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !out_valid)
    else $error("outputs not cleared by reset");
endmodule
bind vipp_top vipp_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .hw_reset_n, .out_valid);

// file: dv/tb_top.sv
// self-checking bench for the video input path
`timescale 1ns/100ps
module tb_top;
  import vipp_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, hw_reset_n = 1'h1, go = 1'h0, slow = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [26:0] wrd = 27'h0;
  logic [3:0] hp = 4'h4;
  logic awready, wready, bvalid, arready, rvalid, ov, pclk, pde, phs, pvs, busy;
  logic [1:0] bresp, rresp;
  logic [23:0] pd;
  vipp_pix_type op, got;
  int error_cnt = 0, comparisons = 0, cyc = 0, run;
  vipp_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hw_reset_n(hw_reset_n), .pix_clk(pclk), .pix_de(pde),
    .pix_hsync(phs), .pix_vsync(pvs), .pix_d(pd), .out_pix(op), .out_valid(ov));
  vipp_src_model u_src (.aclk(aclk), .go(go), .w(wrd), .hp(hp), .pix_clk(pclk),
    .pix_de(pde), .pix_hsync(phs), .pix_vsync(pvs), .pix_d(pd), .busy(busy));
  always #50 aclk = ~aclk;
  // ==========================================
  // reporting
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // the whole run needs about 700 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ==========================================
  // bus and pixel drivers
  // ready is sampled mid-cycle, where it already holds its value for the next edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, hb;
    int n;
    hb = 1'h0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= !slow;
    while (!hb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      hb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      n++;
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (hb) bready <= 1'h0;
      else if (n == 3) bready <= 1'h1;
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, hr;
    int n;
    hr = 1'h0;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= !slow;
    while (!hr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      hr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      n++;
      if (ta) arvalid <= 1'h0;
      if (hr) rready <= 1'h0;
      else if (n == 3) rready <= 1'h1;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk($sformatf("rdata %h", a), d, e);
    chk($sformatf("rresp %h", a), r, er);
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axw(a, d, r);
    chk($sformatf("bresp %h", a), r, er);
  endtask
  // one source word {de, hs, vs, data}; run counts the output cycles
  task automatic px(input logic [26:0] w);
    int n;
    run = 0;
    n = 0;
    @(posedge aclk);
    wrd <= w;
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    while (n < 40 && !(run > 0 && !ov)) begin
      @(negedge aclk);
      n++;
      if (ov) begin
        run++;
        got = op;
      end
    end
    while (busy) @(negedge aclk);
  endtask
  // ==========================================
  // scenarios
  task automatic s_regs;
    rdc(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
    rdc(ADDR_COEF, {16'h0, COEF_UNITY}, RESP_OKAY);
    rdc(ADDR_DEG_H, DEG_RESET, RESP_OKAY);
    slow = 1'h1;
    rdc(8'h40, 32'h0, RESP_SLVERR);
    wrc(8'h44, 32'h1, RESP_SLVERR);
    slow = 1'h0;
    rdc(8'h02, 32'h0, RESP_SLVERR);
    wrc(ADDR_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    wrc(8'h34, 32'hFFFF_0010, RESP_OKAY);
    rdc(8'h34, 32'h0000_0010, RESP_OKAY);
  endtask
  task automatic s_scale;
    int h;
    for (int i = 1; i < 4; i++) begin
      hp <= 4'(3 + i);
      wrc(ADDR_CTRL, {28'h0, 2'(i), FMT_RGB444}, RESP_OKAY);
      px({3'h5, 24'hA5C31E});
      chk("pix data", got.data, 24'hA5C31E);
      chk("pix sync", {got.de, got.hs, got.vs}, 3'h5);
      chk("repeat", run, 32'h1 << (i - 1));
    end
    hp <= 4'h4;
    wrc(ADDR_CTRL, {28'h0, SCALE_HALF, FMT_RGB444}, RESP_OKAY);
    px({3'h4, 24'h123456});
    h = run;
    px({3'h4, 24'h123456});
    chk("half rate", h + run, 32'h1);
  endtask
  task automatic s_swap;
    wrc(ADDR_CTRL, 32'h0000_0105, RESP_OKAY);
    px({3'h4, 24'h112233});
    chk("red blue", got.data, 24'h332211);
  endtask
  task automatic s_matrix;
    wrc(ADDR_CTRL, 32'h0000_0804, RESP_OKAY);
    px({3'h4, 24'h302010});
    chk("matrix", got.data, 24'h302020);
    px({3'h4, 24'h3020F8});
    chk("matrix clamp", got.data, 24'h3020FF);
  endtask
  task automatic send_code(input logic [7:0] xy);
    logic [7:0] seq [4];
    seq = '{SYNC_FF, SYNC_00, SYNC_00, xy};
    foreach (seq[k]) px({3'h4, seq[k], 16'h8010});
  endtask
  task automatic s_embed;
    logic [31:0] d;
    logic [1:0] r;
    wrc(ADDR_CTRL, 32'h0000_0026, RESP_OKAY);
    send_code(8'hD0);
    chk("code de", got.de, 1'h0);
    axr(ADDR_STATUS, d, r);
    chk("xy bits", d[2:0], 3'h5);
    px({3'h4, 24'h008010});
    chk("code flags", {got.fld, got.de, got.hs, got.vs}, 4'hA);
    send_code(8'h80);
    px({3'h4, 24'h008010});
    chk("active de", {got.de, got.hs, got.vs}, 3'h4);
  endtask
  // a pixel with de low first restarts the chroma phase
  task automatic s_modes;
    wrc(ADDR_CTRL, 32'h0000_0286, RESP_OKAY);
    px({3'h7, 24'hABC123});
    chk("de only", {got.de, got.hs, got.vs}, 3'h4);
    chk("luma chroma", got.data, 24'h0012AB);
    wrc(ADDR_CTRL, 32'h0000_0014, RESP_OKAY);
    px({3'h4, 24'h000ABC});
    chk("double edge", got.data, 24'hABCABC);
    chk("double words", run, 32'h1);
    wrc(ADDR_CTRL, 32'h0000_0406, RESP_OKAY);
    px({3'h0, 24'h000000});
    px({3'h4, 24'h401230});
    chk("up first", got.data[15:0], 16'h4023);
    px({3'h4, 24'h505670});
    chk("up second", got.data, 24'h675023);
    wrc(ADDR_CTRL, 32'h0000_1005, RESP_OKAY);
    px({3'h0, 24'h000000});
    px({3'h4, 24'hC3B2A1});
    chk("down even", got.data, 24'h00B2A1);
    px({3'h4, 24'hF6E5D4});
    chk("down odd", got.data, 24'h00E5F6);
    wrc(ADDR_DEG_H, 32'h0001_0001, RESP_OKAY);
    wrc(ADDR_DEG_V, 32'h0001_0000, RESP_OKAY);
    wrc(ADDR_CTRL, 32'h0000_0044, RESP_OKAY);
    px({3'h0, 24'h000000});
    px({3'h3, 24'h000000});
    px({3'h3, 24'h000000});
    chk("gen de on", {got.de, got.hs, got.vs}, 3'h7);
    px({3'h3, 24'h000000});
    chk("gen de off", {got.de, got.hs, got.vs}, 3'h3);
  endtask
  task automatic s_hwrst;
    wrc(ADDR_CTRL, 32'h0000_0805, RESP_OKAY);
    @(posedge aclk);
    hw_reset_n <= 1'h0;
    repeat (6) @(posedge aclk);
    hw_reset_n <= 1'h1;
    repeat (6) @(posedge aclk);
    rdc(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
    rdc(8'h34, {16'h0, COEF_ZERO}, RESP_OKAY);
    px({3'h4, 24'h3020F8});
    chk("after reset", got.data, 24'h3020F8);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    s_regs();
    s_scale();
    s_swap();
    s_matrix();
    s_embed();
    s_modes();
    s_hwrst();
    give_verdict();
  end
endmodule
